/* hdl/oap_regs.svh */
`ifndef OAP_REGS_SVH
`define OAP_REGS_SVH

// Timing
`define OAP_CLK_HZ 50000000
`define OAP_TICK_MS 100
`define OAP_TICK_CYCLES (`OAP_CLK_HZ / 1000 * `OAP_TICK_MS)
`define OAP_BACKLIGHT_S 60
`define OAP_BACKLIGHT_TICKS (`OAP_BACKLIGHT_S * 1000 / `OAP_TICK_MS)
`define OAP_LOG_500MS 500
`define OAP_LOG_1S_MS 1000
`define OAP_LOG_2S_MS 2000
`define OAP_LOG_5S_MS 5000
`define OAP_LOG_TICKS(ms) ((ms) / `OAP_TICK_MS)

// Network port
`define OAP_PORT_DEFAULT 16'h13a1
`define OAP_PORT_RSVD_A 16'h01f6
`define OAP_PORT_RSVD_B 16'h0219

// Factory values of settings
`define OAP_DEF_SB_ONOFF 1'h0
`define OAP_DEF_SB_INVERT 1'h0
`define OAP_DEF_PIN2_MASK 3'h1
`define OAP_DEF_PIN3_DC 1'h0
`define OAP_DEF_PWRON_RESTORE 1'h0
`define OAP_DEF_PF_AUTO 1'h0
`define OAP_DEF_REMOTE_AUTO 1'h0
`define OAP_DEF_OT_AUTO 1'h1
`define OAP_DEF_BACKLIGHT_TO 1'h0
`define OAP_DEF_LOG_EN 1'h0
`define OAP_DEF_LOG_FOLLOW 1'h0
`define OAP_DEF_DHCP_EN 1'h1

// Alarm counter layout
`define OAP_NUM_ALARMS 5
`define OAP_CNT_W 16

`endif

/* hdl/oap_pkg.sv */
package oap_pkg;

    typedef enum logic [1:0] {PIN1_OT, PIN1_PF, PIN1_BOTH} oap_pin1_sel_t;

    typedef enum logic [1:0] {LOG_500MS, LOG_1S, LOG_2S, LOG_5S} oap_log_intv_t;

    typedef enum logic {LOG_IDLE, LOG_RUN} oap_log_state_t;

    // Stored settings; bit 0 of pin2_mask is overvoltage, 1 overcurrent, 2 overpower
    typedef struct packed {
        logic sb_onoff;
        logic sb_invert;
        oap_pin1_sel_t pin1_sel;
        logic [2:0] pin2_mask;
        logic pin3_dc;
        logic pwron_restore;
        logic pf_auto;
        logic remote_auto;
        logic ot_auto;
        logic backlight_to;
        logic log_en;
        logic log_follow;
        oap_log_intv_t log_intv;
        logic dhcp_en;
        logic [15:0] net_port;
    } oap_cfg_t;

    typedef struct packed {
        logic cv;
        logic overpower_alarm;
        logic overcurrent_alarm;
        logic overvoltage_alarm;
        logic pf;
        logic ot;
    } oap_alarm_t;

endpackage

/* hdl/oap_tick_div.sv */
`timescale 1ns/10ps
`default_nettype none

// Divides the system clock into a one-cycle enable
module oap_tick_div #(
    parameter int unsigned CYCLES = 5000000
) (
    input wire logic clk_sys,
    input wire logic nrst,
    output logic tick
);
    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end
        else if (cnt_reg == LAST)
        begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + W'(1);
            tick <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* hdl/oap_alarm_cnt.sv */
`timescale 1ns/10ps
`default_nettype none

// Saturating count of alarm onsets since power-up
module oap_alarm_cnt #(
    parameter int unsigned N = 5,
    parameter int unsigned W = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [N-1:0] alarm,
    output logic [N-1:0][W-1:0] count
);
    logic [N-1:0] prev_reg;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
            prev_reg <= '0;
        else
            prev_reg <= alarm;
    end

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_cnt
            always_ff @(posedge clk_sys)
            begin
                if (!nrst)
                    count[i] <= '0;
                else if (alarm[i] && !prev_reg[i] && count[i] != {W{1'b1}})
                    count[i] <= count[i] + W'(1);
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* hdl/oap_top.sv */
// Function
// - Off-only standby action may switch the power input off, never on.
// - On/off standby action resumes the input only if it was on before.
// - First alarm pin shows overtemperature, power-fail, or either; default either.
// - Second alarm pin ORs any nonempty set of voltage/current/power alarms.
// - Third pin shows constant-voltage indication or input state; default indication.
// - After power-up the input is off; restore policy still holds its factory off value then.
// - Factory default and reset to defaults set power-on policy to off.
// - After power-fail the input stays off; auto policy resumes if it was on.
// - Leaving remote forces the input off; auto policy keeps its state.
// - After overtemperature auto policy restores prior state; off policy keeps off.
// - Backlight turns off after 60 s without activity when enabled.
// - Active logging emits one record per 500 ms, 1 s, 2 s or 5 s.
// - Follow mode starts and stops logging on each input change, new file each start.
// - Manual mode starts and stops logging only by front-panel command.
// - Defaults request restores all settings; restart request triggers a warm start.
// - Initialize request reruns parallel-system discovery.
// - Count each alarm type since power-up and present the counts.
// - Network port accepts 0 to 65535, defaults to 5025, 502 and 537 reserved.
// - Without an answering address server, fall back to manual addressing.
// - Standby level setting inverts the input's active level and function.
`timescale 1ns/10ps
`default_nettype none

`include "oap_regs.svh"

module oap_top #(
    parameter int unsigned TICK_CYCLES = `OAP_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire oap_pkg::oap_cfg_t cfg_in,
    input wire logic defaults_req,
    input wire logic restart_req,
    input wire logic ms_init_req,
    input wire logic stored_dc_on,
    input wire oap_pkg::oap_alarm_t alarms,
    input wire logic remote_active,
    input wire logic dc_on_cmd,
    input wire logic dc_off_cmd,
    input wire logic remote_standby_input,
    input wire logic user_activity,
    input wire logic log_start_cmd,
    input wire logic log_stop_cmd,
    input wire logic dhcp_ack,
    input wire logic dhcp_timeout,
    output oap_pkg::oap_cfg_t cfg_out,
    output logic dc_input_on,
    output logic alarm_pin1,
    output logic alarm_pin2,
    output logic status_pin3,
    output logic backlight_on,
    output logic log_active,
    output logic log_record,
    output logic log_new_file,
    output logic defaults_done,
    output logic warm_start,
    output logic ms_discover,
    output logic port_rejected,
    output logic net_use_manual,
    output logic [`OAP_NUM_ALARMS-1:0][`OAP_CNT_W-1:0] alarm_counts
);
    localparam logic [9:0] BL_TICKS = 10'(`OAP_BACKLIGHT_TICKS);
    localparam logic [5:0] LOG_T0 = 6'(`OAP_LOG_TICKS(`OAP_LOG_500MS));
    localparam logic [5:0] LOG_T1 = 6'(`OAP_LOG_TICKS(`OAP_LOG_1S_MS));
    localparam logic [5:0] LOG_T2 = 6'(`OAP_LOG_TICKS(`OAP_LOG_2S_MS));
    localparam logic [5:0] LOG_T3 = 6'(`OAP_LOG_TICKS(`OAP_LOG_5S_MS));

    function automatic logic port_is_reserved(input logic [15:0] p);
        port_is_reserved = (p == `OAP_PORT_RSVD_A) || (p == `OAP_PORT_RSVD_B);
    endfunction

    function automatic oap_pkg::oap_cfg_t factory_cfg();
        oap_pkg::oap_cfg_t c;
        c.sb_onoff = `OAP_DEF_SB_ONOFF;
        c.sb_invert = `OAP_DEF_SB_INVERT;
        c.pin1_sel = oap_pkg::PIN1_BOTH;
        c.pin2_mask = `OAP_DEF_PIN2_MASK;
        c.pin3_dc = `OAP_DEF_PIN3_DC;
        c.pwron_restore = `OAP_DEF_PWRON_RESTORE;
        c.pf_auto = `OAP_DEF_PF_AUTO;
        c.remote_auto = `OAP_DEF_REMOTE_AUTO;
        c.ot_auto = `OAP_DEF_OT_AUTO;
        c.backlight_to = `OAP_DEF_BACKLIGHT_TO;
        c.log_en = `OAP_DEF_LOG_EN;
        c.log_follow = `OAP_DEF_LOG_FOLLOW;
        c.log_intv = oap_pkg::LOG_500MS;
        c.dhcp_en = `OAP_DEF_DHCP_EN;
        c.net_port = `OAP_PORT_DEFAULT;
        factory_cfg = c;
    endfunction

    function automatic logic [5:0] log_ticks(input oap_pkg::oap_log_intv_t s);
        case (s)
            oap_pkg::LOG_500MS: log_ticks = LOG_T0;
            oap_pkg::LOG_1S: log_ticks = LOG_T1;
            oap_pkg::LOG_2S: log_ticks = LOG_T2;
            default: log_ticks = LOG_T3;
        endcase
    endfunction

    logic tick;
    logic init_reg;
    logic sb_meta_reg;
    logic sb_sync_reg;
    logic sb_prev_reg;
    logic sb_resume_reg;
    logic sb_resume_next;
    logic pf_prev_reg;
    logic ot_prev_reg;
    logic remote_prev_reg;
    logic pf_was_on_reg;
    logic ot_was_on_reg;
    logic dc_next;
    logic dc_prev_reg;
    logic sb_act;
    logic [9:0] bl_cnt_reg;
    logic [5:0] log_cnt_reg;
    logic dhcp_fail_reg;
    oap_pkg::oap_log_state_t log_state_reg;
    oap_pkg::oap_log_state_t log_state_next;

    oap_tick_div #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .tick(tick)
    );

    oap_alarm_cnt #(
        .N(`OAP_NUM_ALARMS),
        .W(`OAP_CNT_W)
    ) u_cnt (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .alarm({alarms.overpower_alarm, alarms.overcurrent_alarm, alarms.overvoltage_alarm, alarms.pf, alarms.ot}),
        .count(alarm_counts)
    );

    // Settings store
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            cfg_out <= factory_cfg();
            port_rejected <= 1'b0;
        end
        else if (defaults_req)
        begin
            cfg_out <= factory_cfg();
            port_rejected <= 1'b0;
        end
        else if (cfg_wr)
        begin
            cfg_out <= cfg_in;
            if (port_is_reserved(cfg_in.net_port))
                cfg_out.net_port <= cfg_out.net_port;
            if (cfg_in.pin2_mask == 3'h0)
                cfg_out.pin2_mask <= cfg_out.pin2_mask;
            if (cfg_in.pin1_sel == 2'h3)
                cfg_out.pin1_sel <= cfg_out.pin1_sel;
            port_rejected <= port_is_reserved(cfg_in.net_port);
        end
    end

    // Request pulses
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            defaults_done <= 1'b0;
            warm_start <= 1'b0;
            ms_discover <= 1'b0;
        end
        else
        begin
            defaults_done <= defaults_req;
            warm_start <= restart_req;
            ms_discover <= ms_init_req;
        end
    end

    // Standby pin synchroniser
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sb_meta_reg <= 1'b0;
            sb_sync_reg <= 1'b0;
        end
        else
        begin
            sb_meta_reg <= remote_standby_input;
            sb_sync_reg <= sb_meta_reg;
        end
    end

    assign sb_act = sb_sync_reg ^ cfg_out.sb_invert;

    // Power input state decision
    always_comb
    begin
        dc_next = dc_input_on;
        sb_resume_next = sb_resume_reg;
        if (init_reg)
        begin
            dc_next = cfg_out.pwron_restore ? stored_dc_on : 1'b0;
            sb_resume_next = 1'b0;
        end
        else
        begin
            if (dc_on_cmd)
                dc_next = 1'b1;
            if (dc_off_cmd)
            begin
                dc_next = 1'b0;
                sb_resume_next = 1'b0;
            end
            if (remote_prev_reg && !remote_active && !cfg_out.remote_auto)
                dc_next = 1'b0;
            if (sb_act && !sb_prev_reg)
            begin
                sb_resume_next = cfg_out.sb_onoff && dc_input_on;
                dc_next = 1'b0;
            end
            if (!sb_act && sb_prev_reg)
            begin
                if (cfg_out.sb_onoff && sb_resume_reg)
                    dc_next = 1'b1;
                sb_resume_next = 1'b0;
            end
            if (!alarms.pf && pf_prev_reg && cfg_out.pf_auto && pf_was_on_reg)
                dc_next = 1'b1;
            if (!alarms.ot && ot_prev_reg && cfg_out.ot_auto && ot_was_on_reg)
                dc_next = 1'b1;
            if (sb_act)
                dc_next = 1'b0;
            if (alarms.pf || alarms.ot)
                dc_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            init_reg <= 1'b1;
            dc_input_on <= 1'b0;
            sb_resume_reg <= 1'b0;
        end
        else
        begin
            init_reg <= 1'b0;
            dc_input_on <= dc_next;
            sb_resume_reg <= sb_resume_next;
        end
    end

    // Edge history and state held at alarm onset
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            sb_prev_reg <= 1'b0;
            pf_prev_reg <= 1'b0;
            ot_prev_reg <= 1'b0;
            remote_prev_reg <= 1'b0;
            pf_was_on_reg <= 1'b0;
            ot_was_on_reg <= 1'b0;
        end
        else
        begin
            sb_prev_reg <= sb_act;
            pf_prev_reg <= alarms.pf;
            ot_prev_reg <= alarms.ot;
            remote_prev_reg <= remote_active;
            if (alarms.pf && !pf_prev_reg)
                pf_was_on_reg <= dc_input_on;
            if (alarms.ot && !ot_prev_reg)
                ot_was_on_reg <= dc_input_on;
        end
    end

    // Analog interface status pins
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            alarm_pin1 <= 1'b0;
            alarm_pin2 <= 1'b0;
            status_pin3 <= 1'b0;
        end
        else
        begin
            case (cfg_out.pin1_sel)
                oap_pkg::PIN1_OT: alarm_pin1 <= alarms.ot;
                oap_pkg::PIN1_PF: alarm_pin1 <= alarms.pf;
                default: alarm_pin1 <= alarms.ot | alarms.pf;
            endcase
            alarm_pin2 <= |(cfg_out.pin2_mask
                & {alarms.overpower_alarm, alarms.overcurrent_alarm, alarms.overvoltage_alarm});
            status_pin3 <= cfg_out.pin3_dc ? dc_input_on : alarms.cv;
        end
    end

    // Backlight inactivity timer
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            bl_cnt_reg <= '0;
            backlight_on <= 1'b1;
        end
        else if (user_activity || !cfg_out.backlight_to)
        begin
            bl_cnt_reg <= '0;
            backlight_on <= 1'b1;
        end
        else if (tick && bl_cnt_reg != BL_TICKS)
        begin
            bl_cnt_reg <= bl_cnt_reg + 10'h001;
            if (bl_cnt_reg == BL_TICKS - 10'h001)
                backlight_on <= 1'b0;
        end
    end

    // Logging control
    always_comb
    begin
        log_state_next = log_state_reg;
        case (log_state_reg)
            oap_pkg::LOG_IDLE:
            begin
                if (cfg_out.log_en && cfg_out.log_follow && dc_input_on && !dc_prev_reg)
                    log_state_next = oap_pkg::LOG_RUN;
                else if (cfg_out.log_en && !cfg_out.log_follow && log_start_cmd)
                    log_state_next = oap_pkg::LOG_RUN;
            end
            default:
            begin
                if (!cfg_out.log_en)
                    log_state_next = oap_pkg::LOG_IDLE;
                else if (cfg_out.log_follow && !dc_input_on && dc_prev_reg)
                    log_state_next = oap_pkg::LOG_IDLE;
                else if (!cfg_out.log_follow && log_stop_cmd)
                    log_state_next = oap_pkg::LOG_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            log_state_reg <= oap_pkg::LOG_IDLE;
            dc_prev_reg <= 1'b0;
            log_active <= 1'b0;
            log_new_file <= 1'b0;
        end
        else
        begin
            log_state_reg <= log_state_next;
            dc_prev_reg <= dc_input_on;
            log_active <= (log_state_next == oap_pkg::LOG_RUN);
            log_new_file <= (log_state_reg == oap_pkg::LOG_IDLE)
                && (log_state_next == oap_pkg::LOG_RUN);
        end
    end

    // Record pacing
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            log_cnt_reg <= '0;
            log_record <= 1'b0;
        end
        else if (log_state_reg != oap_pkg::LOG_RUN)
        begin
            log_cnt_reg <= '0;
            log_record <= 1'b0;
        end
        else if (tick)
        begin
            if (log_cnt_reg >= log_ticks(cfg_out.log_intv) - 6'h01)
            begin
                log_cnt_reg <= '0;
                log_record <= 1'b1;
            end
            else
            begin
                log_cnt_reg <= log_cnt_reg + 6'h01;
                log_record <= 1'b0;
            end
        end
        else
            log_record <= 1'b0;
    end

    // Address fallback; a timeout in the same cycle as an answer wins
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            dhcp_fail_reg <= 1'b0;
            net_use_manual <= 1'b0;
        end
        else
        begin
            if (dhcp_timeout)
                dhcp_fail_reg <= 1'b1;
            else if (dhcp_ack)
                dhcp_fail_reg <= 1'b0;
            net_use_manual <= !cfg_out.dhcp_en || dhcp_timeout || dhcp_fail_reg;
        end
    end
endmodule

`default_nettype wire

/* verif/oap_top_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module oap_chk (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cfg_wr,
    input wire oap_pkg::oap_cfg_t cfg_in,
    input wire logic defaults_req,
    input wire logic restart_req,
    input wire oap_pkg::oap_alarm_t alarms,
    input wire logic remote_active,
    input wire oap_pkg::oap_cfg_t cfg_out,
    input wire logic dc_input_on,
    input wire logic alarm_pin1,
    input wire logic alarm_pin2,
    input wire logic status_pin3,
    input wire logic defaults_done,
    input wire logic warm_start,
    input wire logic port_rejected
);
    logic p1, p2, p3;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // Pin values due one cycle after their causes
    always_ff @(posedge clk_sys)
    begin
        p1 <= (cfg_out.pin1_sel != oap_pkg::PIN1_PF && alarms.ot)
            || (cfg_out.pin1_sel != oap_pkg::PIN1_OT && alarms.pf);
        p2 <= |(cfg_out.pin2_mask & {alarms.overpower_alarm, alarms.overcurrent_alarm, alarms.overvoltage_alarm});
        p3 <= cfg_out.pin3_dc ? dc_input_on : alarms.cv;
    end
    property p_pin1;
        $past(nrst) |-> alarm_pin1 == p1;
    endproperty
    a_pin1: assert property (p_pin1) else $error("pin1 routing wrong");
    property p_pin2;
        $past(nrst) |-> alarm_pin2 == p2;
    endproperty
    a_pin2: assert property (p_pin2) else $error("pin2 routing wrong");
    property p_pin3;
        $past(nrst) |-> status_pin3 == p3;
    endproperty
    a_pin3: assert property (p_pin3) else $error("pin3 routing wrong");
    property p_dflt;
        defaults_req |=> defaults_done && !cfg_out.pwron_restore && cfg_out.net_port == 16'h13a1;
    endproperty
    a_dflt: assert property (p_dflt) else $error("defaults not restored");
    property p_warm;
        restart_req |=> warm_start;
    endproperty
    a_warm: assert property (p_warm) else $error("no warm start");
    property p_alm;
        alarms.ot || alarms.pf |=> !dc_input_on;
    endproperty
    a_alm: assert property (p_alm) else $error("input on during alarm");
    property p_rem;
        $fell(remote_active) && !cfg_out.remote_auto |=> !dc_input_on;
    endproperty
    a_rem: assert property (p_rem) else $error("input on after remote exit");
    property p_port;
        cfg_wr && !defaults_req && (cfg_in.net_port == 16'h01f6 || cfg_in.net_port == 16'h0219)
            |=> port_rejected && $stable(cfg_out.net_port);
    endproperty
    a_port: assert property (p_port) else $error("reserved port taken");
endmodule
bind oap_top oap_chk u_oap_chk (.clk_sys, .nrst, .cfg_wr, .cfg_in, .defaults_req, .restart_req,
    .alarms, .remote_active, .cfg_out, .dc_input_on, .alarm_pin1, .alarm_pin2, .status_pin3,
    .defaults_done, .warm_start, .port_rejected);
`default_nettype wire

/* verif/oap_ext_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
// Outside controller driving the standby pin from a flop
module oap_ext_ctrl (
    input wire logic clk_sys,
    input wire logic standby_req,
    output var logic remote_standby_input = 1'b0
);
    always @(posedge clk_sys)
    begin
        remote_standby_input <= standby_req;
    end
endmodule
`default_nettype wire

/* verif/tb_oap_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_oap_top;
    localparam int TCK = 10;
    localparam int PER [4] = '{5, 10, 20, 50};
    localparam int DFL = 0, RST = 1, MSI = 2, LST = 3, LSP = 4, ACK = 5, TMO = 6, ACT = 7;
    localparam int DON = 8, DOF = 9, WR = 10;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic sb_req = 1'b0;
    logic remote_active = 1'b0;
    logic [10:0] req = '0;
    logic [5:0] alarms = '0;
    oap_pkg::oap_cfg_t cfg_in = '0, cfg_v, fact, cfg_out;
    logic remote_standby_input, dc_input_on, alarm_pin1, alarm_pin2, status_pin3;
    logic backlight_on, log_active, log_record, log_new_file, defaults_done;
    logic warm_start, ms_discover, port_rejected, net_use_manual;
    logic [4:0][15:0] alarm_counts;
    int checks = 0, miscompares = 0;
    always #10 clk_sys = ~clk_sys;
    oap_top #(.TICK_CYCLES(TCK)) u_oap_top (.clk_sys, .nrst, .cfg_wr(req[WR]), .cfg_in,
        .defaults_req(req[DFL]), .restart_req(req[RST]), .ms_init_req(req[MSI]),
        .stored_dc_on(1'b1), .alarms(oap_pkg::oap_alarm_t'(alarms)), .remote_active,
        .dc_on_cmd(req[DON]), .dc_off_cmd(req[DOF]), .remote_standby_input,
        .user_activity(req[ACT]), .log_start_cmd(req[LST]), .log_stop_cmd(req[LSP]),
        .dhcp_ack(req[ACK]), .dhcp_timeout(req[TMO]), .cfg_out, .dc_input_on, .alarm_pin1,
        .alarm_pin2, .status_pin3, .backlight_on, .log_active, .log_record, .log_new_file,
        .defaults_done, .warm_start, .ms_discover, .port_rejected, .net_use_manual,
        .alarm_counts);
    oap_ext_ctrl u_oap_ext_ctrl (.clk_sys, .standby_req(sb_req), .remote_standby_input);
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clk_sys);
        cfg_in <= cfg_v;
        req <= 11'h001 << k;
        @(posedge clk_sys);
        req <= '0;
        #1;
    endtask
    task automatic set_al(input logic [5:0] a);
        @(posedge clk_sys);
        alarms <= a;
        cyc(2);
    endtask
    task automatic set_sb(input logic v);
        @(posedge clk_sys);
        sb_req <= v;
        cyc(6);
    endtask
    task automatic t_pins();
        for (int s = 0; s < 3; s++)
        begin
            cfg_v.pin1_sel = oap_pkg::oap_pin1_sel_t'(s);
            pulse(WR);
            for (int a = 0; a < 4; a++)
            begin
                set_al(6'(a));
                chk(alarm_pin1, (s != 1 && a[0]) || (s != 0 && a[1]));
            end
        end
        for (int m = 1; m < 8; m++)
        begin
            cfg_v.pin2_mask = 3'(m);
            pulse(WR);
            for (int a = 0; a < 8; a++)
            begin
                set_al(6'(a << 2));
                chk(alarm_pin2, (m & a) != 0);
            end
        end
        cfg_v.pin2_mask = 3'h0;
        pulse(WR);
        chkv(64'(cfg_out.pin2_mask), 64'h7);
        set_al(6'h20);
        chk(status_pin3, 1'b1);
        cfg_v.pin3_dc = 1'b1;
        pulse(WR);
        pulse(DON);
        set_al(6'h00);
        chk(status_pin3, 1'b1);
        pulse(DOF);
        cyc(1);
        chk(status_pin3, 1'b0);
    endtask
    task automatic t_sb(input logic inv, input logic oo);
        cfg_v.sb_invert = inv;
        cfg_v.sb_onoff = oo;
        set_sb(inv);
        pulse(WR);
        cyc(3);
        pulse(DON);
        set_sb(!inv);
        chk(dc_input_on, 1'b0);
        set_sb(inv);
        chk(dc_input_on, oo);
        pulse(DOF);
        set_sb(!inv);
        set_sb(inv);
        chk(dc_input_on, 1'b0);
    endtask
    task automatic t_alarm(input logic ot, input logic au);
        cfg_v.ot_auto = au;
        cfg_v.pf_auto = au;
        pulse(WR);
        pulse(DON);
        set_al(ot ? 6'h01 : 6'h02);
        chk(dc_input_on, 1'b0);
        set_al(6'h00);
        chk(dc_input_on, au);
        pulse(DOF);
        @(posedge clk_sys);
        remote_active <= 1'b1;
        cfg_v.remote_auto = au;
        pulse(WR);
        pulse(DON);
        @(posedge clk_sys);
        remote_active <= 1'b0;
        cyc(2);
        chk(dc_input_on, au);
        pulse(DOF);
    endtask
    task automatic t_port();
        logic [15:0] pv [4];
        logic [15:0] last;
        pv = '{16'd502, 16'd0, 16'd537, 16'hffff};
        last = 16'd5025;
        foreach (pv[i])
        begin
            cfg_v.net_port = pv[i];
            pulse(WR);
            if (pv[i] != 16'd502 && pv[i] != 16'd537)
                last = pv[i];
            chk(port_rejected, pv[i] == 16'd502 || pv[i] == 16'd537);
            chkv(64'(cfg_out.net_port), 64'(last));
        end
    endtask
    task automatic t_log();
        int n;
        cfg_v.log_en = 1'b1;
        pulse(WR);
        pulse(LST);
        for (int i = 0; i < 4; i++)
        begin
            cfg_v.log_intv = oap_pkg::oap_log_intv_t'(i);
            pulse(WR);
            cyc(PER[i] * TCK);
            n = 0;
            repeat (2 * PER[i] * TCK)
            begin
                cyc(1);
                n += int'(log_record === 1'b1);
            end
            chkv(64'(n), 64'd2);
        end
        pulse(DON);
        pulse(DOF);
        chk(log_active, 1'b1);
        pulse(LSP);
        chk(log_active, 1'b0);
        cfg_v.log_follow = 1'b1;
        pulse(WR);
        pulse(DON);
        n = 0;
        repeat (3)
        begin
            cyc(1);
            n += int'(log_new_file === 1'b1);
        end
        chkv(64'(n), 64'd1);
        chk(log_active, 1'b1);
        pulse(DOF);
        cyc(2);
        chk(log_active, 1'b0);
    endtask
    task automatic t_misc();
        int n;
        cfg_v.backlight_to = 1'b1;
        pulse(WR);
        pulse(ACT);
        for (n = 0; n < 700 * TCK && backlight_on === 1'b1; n++)
            cyc(1);
        if (n == 700 * TCK)
        begin
            miscompares++;
            report_and_stop();
        end
        chk(n >= 599 * TCK && n <= 601 * TCK, 1'b1);
        pulse(ACT);
        chk(backlight_on, 1'b1);
        pulse(ACK);
        chk(net_use_manual, 1'b0);
        pulse(TMO);
        chk(net_use_manual, 1'b1);
        pulse(ACK);
        cyc(1);
        chk(net_use_manual, 1'b0);
        pulse(DFL);
        chk(defaults_done, 1'b1);
        chkv(64'(cfg_out), 64'(fact));
        pulse(RST);
        chk(warm_start, 1'b1);
        pulse(MSI);
        chk(ms_discover, 1'b1);
    endtask
    initial
    begin
        fact = '0;
        fact.pin1_sel = oap_pkg::PIN1_BOTH;
        fact.pin2_mask = 3'h1;
        fact.ot_auto = 1'b1;
        fact.dhcp_en = 1'b1;
        fact.net_port = 16'd5025;
        cfg_v = fact;
        cyc(11);
        chk(backlight_on, 1'b1);
        chkv(64'(cfg_out), 64'(fact));
        @(posedge clk_sys);
        nrst <= 1'b1;
        cyc(3);
        chk(dc_input_on, 1'b0);
        repeat (2)
        begin
            set_al(6'h04);
            set_al(6'h00);
        end
        chkv(64'(alarm_counts[2]), 64'd2);
        chkv(64'(alarm_counts[0]), 64'd0);
        t_pins();
        t_sb(1'b1, 1'b0);
        t_sb(1'b1, 1'b1);
        t_sb(1'b0, 1'b0);
        t_sb(1'b0, 1'b1);
        for (int i = 0; i < 4; i++)
            t_alarm(i[0], i[1]);
        t_port();
        t_log();
        t_misc();
        report_and_stop();
    end
endmodule
`default_nettype wire
